/* File: srh_host.sv */
/*
 * Host-side controller for a 2,048 x 8 asynchronous static RAM.
 * Assumes the RAM pins are wired directly, inputs synchronous to core_clk_i,
 * and a testbench that resolves the data pins from dq_oe_n_o.
 */
// Notes on behaviour
// - Write by holding select low and pulsing read/write low.
// - Write by holding read/write low and pulsing select low.
// - Write by presenting address then pulsing select and read/write low.
// - Host changes no address or read/write and drives no data during standby, except around select and combined strobe writes.
`include "srh_defs.svh"

module srh_host
    import srh_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               nrst_i,
    // User request
    input  wire logic               req_valid_i,
    input  wire logic               req_write_i,
    input  wire logic [1:0]         req_wmode_i,
    input  wire logic [`SRH_AW-1:0] req_addr_i,
    input  wire logic [`SRH_DW-1:0] req_wdata_i,
    output logic                    req_ready_o,
    // User response
    output logic                    rsp_valid_o,
    output logic [`SRH_DW-1:0]      rsp_rdata_o,
    // RAM pins
    output logic [`SRH_AW-1:0]      ram_addr_o,
    output logic                    ram_sel_n_o,
    output logic                    ram_oe_n_o,
    output logic                    ram_rw_o,
    input  wire logic [`SRH_DW-1:0] ram_dq_i,
    output logic [`SRH_DW-1:0]      ram_dq_o,
    output logic                    ram_dq_oe_n_o
);

    // ------------------------------------------------------------------------
    // Phase lengths, loaded into the timer as length minus one
    // ------------------------------------------------------------------------
    localparam logic [`SRH_CNT_W-1:0] ACC_LD  = `SRH_CNT_W'(`SRH_ACC_CYC - 1);
    localparam logic [`SRH_CNT_W-1:0] WP_LD   = `SRH_CNT_W'(`SRH_WP_CYC - 1);
    localparam logic [`SRH_CNT_W-1:0] WREC_LD = `SRH_CNT_W'(`SRH_WREC_CYC - 1);
    localparam logic [`SRH_CNT_W-1:0] HZ_LD   = `SRH_CNT_W'(`SRH_HZ_CYC - 1);

    srh_host_st_t          st;
    srh_host_st_t          next_st;
    logic                  tmr_load;
    logic [`SRH_CNT_W-1:0] tmr_val;
    logic                  tmr_zero;

    // Pins at rest: deselected, not driving, address held
    function automatic srh_pins_t idle_pins(input logic [`SRH_AW-1:0] addr);
        srh_pins_t p;
        p         = '0;
        p.addr    = addr;
        p.dq_oe_n = 1'b1;
        p.sel_n   = 1'b1;
        p.oe_n    = 1'b1;
        p.rw      = 1'b1;
        return p;
    endfunction : idle_pins

    // ------------------------------------------------------------------------
    // Phase timer
    // ------------------------------------------------------------------------
    srh_timer u_timer (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .load_i     (tmr_load),
        .load_val_i (tmr_val),
        .zero_o     (tmr_zero)
    );

    // ------------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        next_st           = st;
        next_st.rsp_valid = 1'b0;
        tmr_load          = 1'b0;
        tmr_val           = '0;
        case (st.fsm)
            SRH_IDLE: begin
                if (req_valid_i) begin
                    next_st.req.write = req_write_i;
                    next_st.req.wmode = srh_wmode_t'(req_wmode_i);
                    next_st.req.addr  = req_addr_i;
                    next_st.req.wdata = req_wdata_i;
                    next_st.ready     = 1'b0;
                    next_st.fsm       = SRH_SETUP;
                    next_st.pins.addr = req_addr_i;
                    if (req_write_i) begin
                        // select held low before a read/write strobe
                        // read/write held low before a select strobe
                        next_st.pins.dq      = req_wdata_i;
                        next_st.pins.dq_oe_n = 1'b0;
                        next_st.pins.sel_n   = (srh_wmode_t'(req_wmode_i) != SRH_WM_RW);
                        next_st.pins.rw      = (srh_wmode_t'(req_wmode_i) != SRH_WM_SEL);
                    end else begin
                        // select and output enable low, read/write high
                        next_st.pins.sel_n = 1'b0;
                        next_st.pins.oe_n  = 1'b0;
                    end
                end
            end
            SRH_SETUP: begin
                // Open the joint low interval for writes
                next_st.fsm = SRH_ACTIVE;
                tmr_load    = 1'b1;
                tmr_val     = st.req.write ? WP_LD : ACC_LD;
                if (st.req.write) begin
                    next_st.pins.sel_n = 1'b0;
                    next_st.pins.rw    = 1'b0;
                end
            end
            SRH_ACTIVE: begin
                if (tmr_zero) begin
                    next_st.fsm       = SRH_RECOVER;
                    next_st.rsp_valid = 1'b1;
                    tmr_load          = 1'b1;
                    if (st.req.write) begin
                        // data stays driven across the closing edge
                        tmr_val            = WREC_LD;
                        next_st.pins.sel_n = (st.req.wmode != SRH_WM_RW);
                        next_st.pins.rw    = (st.req.wmode != SRH_WM_SEL);
                    end else begin
                        // sample the stored byte after access time
                        tmr_val           = HZ_LD;
                        next_st.rdata     = ram_dq_i;
                        next_st.pins.sel_n = 1'b1;
                        next_st.pins.oe_n  = 1'b1;
                    end
                end
            end
            SRH_RECOVER: begin
                // wait for the RAM to float before any new drive
                // return to standby with no data driven
                next_st.pins = idle_pins(st.pins.addr);
                if (tmr_zero) begin
                    next_st.fsm   = SRH_IDLE;
                    next_st.ready = 1'b1;
                end
            end
            default: begin
                next_st.fsm   = SRH_IDLE;
                next_st.pins  = idle_pins(st.pins.addr);
                next_st.ready = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            st       <= '0;
            st.pins  <= idle_pins('0);
            st.ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign req_ready_o   = st.ready;
    assign rsp_valid_o   = st.rsp_valid;
    assign rsp_rdata_o   = st.rdata;
    assign ram_addr_o    = st.pins.addr;
    assign ram_sel_n_o   = st.pins.sel_n;
    assign ram_oe_n_o    = st.pins.oe_n;
    assign ram_rw_o      = st.pins.rw;
    assign ram_dq_o      = st.pins.dq;
    assign ram_dq_oe_n_o = st.pins.dq_oe_n;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    a_read_pin_setup: assert property (
        !ram_oe_n_o |-> !ram_sel_n_o && ram_rw_o && ram_dq_oe_n_o)
        else $error("read enable without select or with write");

    a_no_drive_clash: assert property (
        !ram_dq_oe_n_o |-> ram_oe_n_o && $past(ram_oe_n_o))
        else $error("host drives data while RAM may drive");

    a_standby_quiet: assert property (
        ram_sel_n_o && ram_rw_o && $past(ram_sel_n_o) && $past(ram_rw_o)
        |-> $stable(ram_addr_o) || $past(st.fsm) == SRH_IDLE)
        else $error("address moved during standby");

    a_rw_strobe: assert property (
        st.fsm == SRH_SETUP && st.req.write && st.req.wmode == SRH_WM_RW
        |-> !ram_sel_n_o && ram_rw_o ##1 (!ram_sel_n_o && !ram_rw_o)[*8]
            ##1 (!ram_sel_n_o && !ram_rw_o) ##1 (!ram_sel_n_o && ram_rw_o))
        else $error("read/write strobe method out of order");

    a_sel_strobe: assert property (
        st.fsm == SRH_SETUP && st.req.write && st.req.wmode == SRH_WM_SEL
        |-> ram_sel_n_o && !ram_rw_o ##1 (!ram_sel_n_o && !ram_rw_o)[*8]
            ##1 (!ram_sel_n_o && !ram_rw_o) ##1 (ram_sel_n_o && !ram_rw_o))
        else $error("select strobe method out of order");

    a_both_strobe: assert property (
        st.fsm == SRH_SETUP && st.req.write && st.req.wmode == SRH_WM_BOTH
        |-> ram_sel_n_o && ram_rw_o && !ram_dq_oe_n_o
            ##1 (!ram_sel_n_o && !ram_rw_o)[*8] ##1 (!ram_sel_n_o && !ram_rw_o)
            ##1 (ram_sel_n_o && ram_rw_o))
        else $error("combined strobe method out of order");

    a_data_at_close: assert property (
        !$past(ram_sel_n_o) && !$past(ram_rw_o) && (ram_sel_n_o || ram_rw_o)
        |-> !ram_dq_oe_n_o && $stable(ram_dq_o) && $stable(ram_addr_o))
        else $error("write data not held across closing edge");

    a_read_latency: assert property (
        $fell(ram_oe_n_o) |-> (!ram_oe_n_o)[*8] ##1 (!ram_oe_n_o)[*6]
            ##1 (rsp_valid_o && ram_oe_n_o))
        else $error("read answer not after full access time");

    a_idle_standby: assert property (
        st.fsm == SRH_IDLE |-> ram_sel_n_o && ram_dq_oe_n_o && ram_oe_n_o)
        else $error("idle controller not in standby");

endmodule : srh_host

/* File: srh_defs.svh */
/*
 * Constants for the host-side controller of a 2K x 8 asynchronous static RAM.
 * Assumes a single 125 MHz core clock; all times are in nanoseconds.
 */
`ifndef SRH_DEFS_SVH
`define SRH_DEFS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define SRH_AW        11
`define SRH_DW        8
`define SRH_CNT_W     4

// ----------------------------------------------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------------------------------------------
`define SRH_CLK_NS    8
`define SRH_T_ACC_NS  100
`define SRH_T_WP_NS   65
`define SRH_T_WC_NS   100
`define SRH_T_HZ_NS   40
`define SRH_CEIL(ns)  (((ns) + `SRH_CLK_NS - 1) / `SRH_CLK_NS)
`define SRH_ACC_CYC   `SRH_CEIL(`SRH_T_ACC_NS)
`define SRH_WP_CYC    `SRH_CEIL(`SRH_T_WP_NS)
`define SRH_WREC_CYC  `SRH_CEIL(`SRH_T_WC_NS - `SRH_T_WP_NS)
`define SRH_HZ_CYC    `SRH_CEIL(`SRH_T_HZ_NS)

`endif

/* File: srh_pkg.sv */
/*
 * Types for the static RAM host controller.
 * Assumes srh_defs.svh is on the include path.
 */
`include "srh_defs.svh"

package srh_pkg;

    // ------------------------------------------------------------------------
    // Sequencer states, Gray coded along the access path
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRH_IDLE    = 2'b00,
        SRH_SETUP   = 2'b01,
        SRH_ACTIVE  = 2'b11,
        SRH_RECOVER = 2'b10
    } srh_state_t;

    // Write method: strobe on read/write, strobe on select, or both
    typedef enum logic [1:0] {
        SRH_WM_RW   = 2'b00,
        SRH_WM_SEL  = 2'b01,
        SRH_WM_BOTH = 2'b10
    } srh_wmode_t;

    // ------------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic               write;
        srh_wmode_t         wmode;
        logic [`SRH_AW-1:0] addr;
        logic [`SRH_DW-1:0] wdata;
    } srh_req_t;

    typedef struct packed {
        logic [`SRH_AW-1:0] addr;
        logic [`SRH_DW-1:0] dq;
        logic               dq_oe_n;
        logic               sel_n;
        logic               oe_n;
        logic               rw;
    } srh_pins_t;

    typedef struct packed {
        srh_state_t         fsm;
        srh_req_t           req;
        srh_pins_t          pins;
        logic [`SRH_DW-1:0] rdata;
        logic               rsp_valid;
        logic               ready;
    } srh_host_st_t;

    typedef struct packed {
        logic [`SRH_CNT_W-1:0] cnt;
    } srh_tmr_st_t;

endpackage : srh_pkg

/* File: srh_timer.sv */
/*
 * Down counter that times each phase of a RAM access.
 * Assumes the caller loads it with the phase length minus one.
 */
`include "srh_defs.svh"

module srh_timer
    import srh_pkg::*;
(
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  nrst_i,
    // Control
    input  wire logic                  load_i,
    input  wire logic [`SRH_CNT_W-1:0] load_val_i,
    // Status
    output logic                       zero_o
);

    srh_tmr_st_t st;
    srh_tmr_st_t next_st;

    // Load, else count down and rest at zero
    always_comb begin
        next_st = st;
        if (load_i) begin
            next_st.cnt = load_val_i;
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - `SRH_CNT_W'(1);
        end
    end

    // State register
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign zero_o = (st.cnt == '0);

endmodule : srh_timer

/* File: srh_ram_model.sv */
/*
 * Behavioural model of the 2K x 8 static RAM on the far side of the host.
 * Assumes the testbench feeds it the host pins; it returns the resolved bus.
 */
`include "srh_defs.svh"

module srh_ram_model
    import srh_pkg::*;
#(
    parameter int ACC_NS = 100
)(
    // Host pins
    input  wire logic [`SRH_AW-1:0] addr_i,
    input  wire logic               sel_n_i,
    input  wire logic               oe_n_i,
    input  wire logic               rw_i,
    input  wire logic [`SRH_DW-1:0] host_dq_i,
    input  wire logic               host_dq_oe_n_i,
    // Resolved bus and clash flag
    output logic [`SRH_DW-1:0]      dq_o,
    output logic                    clash_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Storage and drive
    // ------------------------------------------------------------------
    // word array
    logic [`SRH_DW-1:0] mem [0:2047];
    logic               drv;
    logic               joint_hi;
    realtime            t_chg;

    assign drv      = !sel_n_i && !oe_n_i && rw_i;
    assign clash_o  = drv && !host_dq_oe_n_i;
    assign joint_hi = sel_n_i | rw_i;

    // Restart access time on any control change
    always @(addr_i or sel_n_i or oe_n_i or rw_i) t_chg = $realtime;

    // Bus level; floating lines toggle so stale data never reads back
    initial begin
        dq_o = 8'h96;
        forever begin
            #1;
            if (!host_dq_oe_n_i) dq_o = host_dq_i;
            else if (drv && ($realtime - t_chg >= ACC_NS)) dq_o = mem[addr_i];
            else dq_o = ~dq_o;
        end
    end

    // capture at end of joint low
    always @(posedge joint_hi) begin
        if ($realtime > 0) mem[addr_i] = dq_o;
    end
endmodule : srh_ram_model

/* File: srh_host_tb.sv */
/*
 * Self-checking testbench for the static RAM host controller.
 * Assumes srh_ram_model stands on the RAM pins and resolves the data bus.
 */
`include "srh_defs.svh"

module srh_host_tb
    import srh_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic               core_clk_i = 1'b0;
    logic               nrst_i = 1'b0;
    logic               req_valid, req_write, req_ready, rsp_valid;
    logic [1:0]         req_wmode;
    logic [`SRH_AW-1:0] req_addr, ram_addr;
    logic [`SRH_DW-1:0] req_wdata, rsp_rdata, ram_dq, host_dq;
    logic               sel_n, oe_n, rw, host_oe_n, clash;
    int                 n_fail = 0;
    int                 num_checks = 0;
    int                 cyc = 0;

    // Clock
    always #4 core_clk_i = ~core_clk_i;

    srh_host dut_u (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .req_valid_i(req_valid), .req_write_i(req_write), .req_wmode_i(req_wmode),
        .req_addr_i(req_addr), .req_wdata_i(req_wdata), .req_ready_o(req_ready),
        .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata),
        .ram_addr_o(ram_addr), .ram_sel_n_o(sel_n), .ram_oe_n_o(oe_n),
        .ram_rw_o(rw), .ram_dq_i(ram_dq), .ram_dq_o(host_dq),
        .ram_dq_oe_n_o(host_oe_n)
    );

    srh_ram_model #(.ACC_NS(100)) ram_u (
        .addr_i(ram_addr), .sel_n_i(sel_n), .oe_n_i(oe_n), .rw_i(rw),
        .host_dq_i(host_dq), .host_dq_oe_n_i(host_oe_n),
        .dq_o(ram_dq), .clash_o(clash)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic complete_run();
        if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // One request; optional second request held while busy
    task automatic do_req(input logic wr, input logic [1:0] m, input logic [10:0] a,
                          input logic [7:0] d, input logic busy_req,
                          output logic [7:0] q, output int t_rsp, output int t_rdy);
        chk("ready before take", 1, req_ready);
        req_valid = 1'b1;
        req_write = wr;
        req_wmode = m;
        req_addr  = a;
        req_wdata = d;
        @(posedge core_clk_i);
        #1;
        req_valid = busy_req;
        req_addr  = ~a;
        req_wdata = 8'hff;
        t_rsp = 0;
        t_rdy = 0;
        for (int n = 1; n < 40; n++) begin
            if (n == 10) req_valid = 1'b0;
            if (rsp_valid === 1'b1 && t_rsp == 0) begin
                t_rsp = n;
                q = rsp_rdata;
            end
            if (req_ready === 1'b1) begin
                t_rdy = n;
                break;
            end
            @(posedge core_clk_i);
            #1;
        end
    endtask : do_req

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk("ready", 1, req_ready);
        chk("pins idle", 4'hb, {sel_n, oe_n, rw, host_oe_n} & 4'hb);
        chk("sel oe rw dqoe", 4'hf, {sel_n, oe_n, rw, host_oe_n});
        chk("rsp_valid", 0, rsp_valid);
        chk("addr rdata", 0, {ram_addr, rsp_rdata});
    endtask : t_reset

    // One write per method, at the two end addresses and one middle address in turn, then read back
    task automatic t_modes();
        logic [10:0] a [3] = '{11'h000, 11'h7ff, 11'h2a5};
        logic [7:0]  d [3] = '{8'h5a, 8'ha5, 8'h3c};
        logic [7:0]  q;
        int          tr, ty;
        for (int m = 0; m < 3; m++) begin
            do_req(1'b1, m[1:0], a[m], d[m], 1'b0, q, tr, ty);
            chk("write rsp cycle", 11, tr);
            chk("write ready cycle", 16, ty);
        end
        for (int m = 0; m < 3; m++) begin
            do_req(1'b0, 2'h0, a[m], 8'h00, 1'b0, q, tr, ty);
            chk("read rsp cycle", 15, tr);
            chk("read ready cycle", 20, ty);
            chk("read data", d[m], q);
        end
    endtask : t_modes

    // Overwrite with a request held while busy, which must be refused
    task automatic t_refuse();
        logic [7:0] q;
        int         tr, ty;
        do_req(1'b1, 2'h2, 11'h7ff, 8'hc3, 1'b1, q, tr, ty);
        do_req(1'b0, 2'h0, 11'h000, 8'h00, 1'b0, q, tr, ty);
        chk("untouched word", 8'h5a, q);
        do_req(1'b0, 2'h0, 11'h7ff, 8'h00, 1'b1, q, tr, ty);
        chk("overwritten word", 8'hc3, q);
    endtask : t_refuse

    // ------------------------------------------------------------------
    // Monitors and main sequence
    // ------------------------------------------------------------------
    always @(negedge core_clk_i) begin
        cyc++;
        if (cyc >= 4000) begin
            n_fail++;
            complete_run();
        end
        if (nrst_i === 1'b1 && clash !== 1'b0) chk("bus clash", 0, clash);
        if (oe_n === 1'b0) chk("rw high in read", 1, rw);
        if (sel_n === 1'b1) chk("no enable in standby", 1, oe_n);
    end

    initial begin
        {req_valid, req_write, req_wmode, req_addr, req_wdata} = '0;
        repeat (4) @(posedge core_clk_i);
        #1;
        t_reset();
        nrst_i = 1'b1;
        t_modes();
        t_refuse();
        complete_run();
    end
endmodule : srh_host_tb
